// [src/cfg_pkg.sv]
// Constants for the address configuration and base port decode block
package cfg_pkg;
  // ------------------------------------------------------------
  // Fixed I/O addresses
  // ------------------------------------------------------------
  localparam logic [9:0] KEY_229 = 10'h229;
  localparam logic [9:0] KEY_22B = 10'h22B;
  localparam logic [9:0] KEY_22D = 10'h22D;
  localparam logic [9:0] KEY_22F = 10'h22F;
  localparam logic [9:0] JOY_FIXED = 10'h201;
  localparam logic [9:0] SC_INDEX_ADDR = 10'h0E0;
  localparam logic [9:0] SC_DATA_ADDR = 10'h0E1;
  localparam logic [9:0] SC_UNLOCK_ADDR = 10'h0F9;
  localparam logic [9:0] SC_LOCK_ADDR = 10'h0FB;
  localparam logic [5:0] AUDIO_HI = 6'h22;
  localparam logic [7:0] JOY_HI = 8'h80;
  localparam logic [3:0] FM_HI = 4'hE;
  localparam logic [3:0] FM_LO = 4'h8;
  localparam logic [3:0] KEY_ZONE = 4'h0;
  // ------------------------------------------------------------
  // Offsets from the audio base
  // ------------------------------------------------------------
  localparam logic [3:0] OFS_FM3 = 4'h3;
  localparam logic [3:0] OFS_IDX = 4'h4;
  localparam logic [3:0] OFS_DAT = 4'h5;
  localparam logic [3:0] OFS_RST = 4'h6;
  localparam logic [3:0] OFS_FM8 = 4'h8;
  localparam logic [3:0] OFS_FM9 = 4'h9;
  localparam logic [3:0] OFS_RDD = 4'hA;
  localparam logic [3:0] OFS_CMD = 4'hC;
  localparam logic [3:0] OFS_BUF = 4'hE;
  localparam logic [3:0] OFS_F2 = 4'h2;
  // ------------------------------------------------------------
  // Mixer registers and fields
  // ------------------------------------------------------------
  localparam logic [6:0] MIX_CFG = 7'h40;
  localparam logic [6:0] MIX_SER = 7'h48;
  localparam int MIX_DISABLE_BIT = 2;
  localparam int MIX_JOYFIX_BIT = 1;
  localparam int MIX_FMALIAS_BIT = 0;
  localparam int SER_SW_BIT = 7;
  localparam int SER_RST_BIT = 5;
  localparam int SER_WT_BIT = 4;
  // System control word fields and reset value
  localparam int SCW_JOY_EN = 3;
  localparam int SCW_AUD_EN = 2;
  localparam logic [7:0] SCW_RESET = 8'h00;
  localparam logic [7:0] SC_INDEX_ZERO = 8'h00;
  localparam logic [2:0] ACT_ALL = 3'h7;
  localparam logic [3:0] LEG_LAST = 4'hA;
  // New key tracker states, Gray coded along the sequence
  typedef enum logic [3:0] {
    K0 = 4'h0, K1 = 4'h1, K2 = 4'h3, K3 = 4'h2, K4 = 4'h6,
    K5 = 4'h7, K6 = 4'h5, K7 = 4'h4, K8 = 4'hC, K9 = 4'hD
  } key_state_t;
endpackage

// [src/isa_address_key_config.sv]
// Address key tracker, system control word and base port decode
// ------------------------------------------------------------
// Behaviour
// - Low mode: track seven-read new key
// - Eighth read sets audio base and enable
// - Ninth read puts joystick {valid, code} in bits 5:3
// - Tenth read sets FM base, else 388h
// - Legacy key sets bits 2:0, rearmable
// - Legacy key aborts on write, stray read
// - Legacy ten reads then audio base read
// - Enabled ignores legacy; mixer 40h disables
// - High mode: unlock, index, data, relock
// - Lock strobes ignore written data
// - Control word field layout
// - Mixer 40h bit1 fixes joystick 201h
// - Mixer 40h bit0 adds FM alias
// - Ports decoded relative to bases
// - Mixer index then data port access
// - Port +6 holds FIFO and core reset
// - Reading +6 sets activity bits high
// - Qualifying accesses clear activity bits
// - Serial activity status bit 4
// - MIDI mode status bit 2
// - Only configuration decode until enabled
// - New key: write aborts, bad read restarts
// ------------------------------------------------------------
module isa_address_key_config
  import cfg_pkg::*;
#(
  parameter int WT_IDLE_CYCLES = 256
) (
  // Clock and reset
  input wire logic clock_i,
  input wire logic arst_n_i,
  // I/O cycle, one cycle strobes
  input wire logic [9:0] io_addr_i,
  input wire logic io_rd_i,
  input wire logic io_wr_i,
  input wire logic io_dack_i,
  input wire logic [7:0] io_wdata_i,
  output logic [7:0] io_rdata_o,
  output logic io_claim_o,
  // Straps and status inputs
  input wire logic addr_method_select_pin_i,
  input wire logic serial_takeover_pin_i,
  input wire logic wavetable_bit_clock_i,
  input wire logic midi_cmd_active_i,
  input wire logic digital_powered_i,
  input wire logic midi_access_i,
  // Mixer side
  input wire logic [7:0] mixer_rdata_i,
  output logic [6:0] mixer_index_o,
  output logic [7:0] mixer_wdata_o,
  output logic mixer_wr_o,
  // Configuration and decode results
  output logic [7:0] system_control_word_o,
  output logic core_hold_reset_o,
  output logic fifo_hold_reset_o,
  output logic audio_hit_o,
  output logic fm_hit_o,
  output logic joy_hit_o
);
  // ------------------------------------------------------------
  // Address classifiers
  // ------------------------------------------------------------
  // Each returns {valid, code}
  // Bases 220h..250h step by 10h, so the code is the distance from 22xh
  function automatic logic [2:0] audio_code(input logic [9:0] a);
    logic [5:0] step;
    step = a[9:4] - AUDIO_HI;
    audio_code = {step[5:2] == 4'h0 && a[3:0] == KEY_ZONE, step[1:0]};
  endfunction
  function automatic logic [2:0] joy_code(input logic [9:0] a);
    joy_code = {a[9:2] == JOY_HI, a[1:0]};
  endfunction
  function automatic logic [2:0] fm_code(input logic [9:0] a);
    fm_code = {a[9:6] == FM_HI && a[3:0] == FM_LO, a[5:4]};
  endfunction
  function automatic logic [9:0] key_expect(input key_state_t s);
    case (s)
      K0: key_expect = KEY_22B;
      K1: key_expect = KEY_229;
      K2: key_expect = KEY_22F;
      K3: key_expect = KEY_22D;
      K4: key_expect = KEY_22D;
      K5: key_expect = KEY_22F;
      default: key_expect = KEY_229;
    endcase
  endfunction
  function automatic logic [9:0] leg_expect(input logic [3:0] n);
    leg_expect = (n == 4'h3 || n == 4'h5 || n == 4'h8) ? KEY_22B : KEY_229;
  endfunction

  // State
  key_state_t key_reg, key_next;
  logic [7:0] scw_reg;
  logic [3:0] leg_reg;
  logic [1:0] run229_reg;
  logic armed_reg, unlock_reg;
  logic [7:0] scidx_reg;
  logic [1:0] mix40_reg;
  logic [2:0] mix48_reg;
  logic [2:0] act_reg;
  logic wt_prev_reg;
  logic [$clog2(WT_IDLE_CYCLES+1)-1:0] wt_cnt_reg;

  // Non-DMA cycles drive the key trackers; DMA is transparent
  logic rd_n, wr_n, hi_mode, in_aud, mix_wr;
  logic [9:0] aud_base, joy_base, fm_base;
  logic [3:0] ofs;
  logic [2:0] aud_c, joy_c, fm_c;
  assign rd_n = io_rd_i & ~io_dack_i;
  assign wr_n = io_wr_i & ~io_dack_i;
  assign hi_mode = addr_method_select_pin_i;
  assign aud_base = {AUDIO_HI + {4'h0, scw_reg[1:0]}, 4'h0};
  assign joy_base = {JOY_HI, scw_reg[5:4]};
  assign fm_base = {FM_HI, scw_reg[7:6], FM_LO};
  assign ofs = io_addr_i[3:0];
  // Classified once; a select on a call result is not portable
  assign aud_c = audio_code(io_addr_i);
  assign joy_c = joy_code(io_addr_i);
  assign fm_c = fm_code(io_addr_i);
  // Audio window only exists once enabled
  assign in_aud = scw_reg[SCW_AUD_EN] && io_addr_i[9:4] == aud_base[9:4];
  assign mix_wr = io_wr_i && in_aud && ofs == OFS_DAT;

  // ------------------------------------------------------------
  // New key tracker
  // ------------------------------------------------------------
  // A wrong read restarts, but a 22Bh read counts as a fresh start
  always_comb begin
    key_next = key_reg;
    if (hi_mode || wr_n) begin
      key_next = K0;
    end else if (rd_n) begin
      case (key_reg)
        K7: key_next = K8;
        K8: key_next = K9;
        K9: key_next = K0;
        default: begin
          if (io_addr_i != key_expect(key_reg)) begin
            key_next = (io_addr_i == KEY_22B) ? K1 : K0;
          end else begin
            case (key_reg)
              K0: key_next = K1;
              K1: key_next = K2;
              K2: key_next = K3;
              K3: key_next = K4;
              K4: key_next = K5;
              K5: key_next = K6;
              default: key_next = K7;
            endcase
          end
        end
      endcase
    end
  end
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) key_reg <= K0;
    else key_reg <= key_next;
  end

  // ------------------------------------------------------------
  // Legacy key tracker
  // ------------------------------------------------------------
  // Three 229h reads in a row always land at step three
  logic leg_live, leg_done;
  assign leg_live = !hi_mode && armed_reg && !scw_reg[SCW_AUD_EN];
  assign leg_done = leg_live && rd_n && leg_reg == LEG_LAST && aud_c[2];
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      leg_reg <= 4'h0;
      run229_reg <= 2'h0;
    end else if (!leg_live || wr_n) begin
      leg_reg <= 4'h0;
      run229_reg <= 2'h0;
    end else if (rd_n) begin
      run229_reg <= (io_addr_i == KEY_229) ? {run229_reg[0] | run229_reg[1], 1'b1} : 2'h0;
      if (io_addr_i == KEY_229 && run229_reg == 2'h3) leg_reg <= 4'h3;
      else if (leg_reg == LEG_LAST) leg_reg <= 4'h0;
      else if (io_addr_i == leg_expect(leg_reg)) leg_reg <= leg_reg + 4'h1;
      else leg_reg <= (io_addr_i == KEY_229) ? 4'h1 : 4'h0;
    end
  end

  // ------------------------------------------------------------
  // System control word
  // ------------------------------------------------------------
  // Mixer 40h bit 2 acts like a hardware reset of the configuration
  logic mix_disable;
  assign mix_disable = mix_wr && mixer_index_o == MIX_CFG && io_wdata_i[MIX_DISABLE_BIT];
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      scw_reg <= SCW_RESET;
      armed_reg <= 1'b1;
    end else if (mix_disable) begin
      scw_reg <= SCW_RESET;
      armed_reg <= 1'b1;
    end else if (leg_done) begin
      scw_reg[2:0] <= {1'b1, aud_c[1:0]};
      armed_reg <= 1'b0;
    end else if (!hi_mode && rd_n && key_reg == K7) begin
      scw_reg[2:0] <= aud_c;
    end else if (!hi_mode && rd_n && key_reg == K8) begin
      scw_reg[5:3] <= joy_c;
    end else if (!hi_mode && rd_n && key_reg == K9) begin
      scw_reg[7:6] <= fm_c[2] ? fm_c[1:0] : 2'h0;
    end else if (hi_mode && io_wr_i && unlock_reg && io_addr_i == SC_DATA_ADDR
                 && scidx_reg == SC_INDEX_ZERO) begin
      scw_reg <= io_wdata_i;
    end
  end

  // Unlock and index; data on the strobes is ignored
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      unlock_reg <= 1'b0;
      scidx_reg <= SC_INDEX_ZERO;
    end else if (hi_mode && io_wr_i) begin
      if (io_addr_i == SC_UNLOCK_ADDR) unlock_reg <= 1'b1;
      else if (io_addr_i == SC_LOCK_ADDR) unlock_reg <= 1'b0;
      else if (io_addr_i == SC_INDEX_ADDR) scidx_reg <= io_wdata_i;
    end
  end

  // ------------------------------------------------------------
  // Mixer port and local snoop of 40h and 48h
  // ------------------------------------------------------------
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      mixer_index_o <= 7'h00;
      mixer_wdata_o <= 8'h00;
      mixer_wr_o <= 1'b0;
      mix40_reg <= 2'h0;
      mix48_reg <= 3'h0;
    end else begin
      mixer_wr_o <= mix_wr;
      if (mix_wr) mixer_wdata_o <= io_wdata_i;
      if (io_wr_i && in_aud && ofs == OFS_IDX) mixer_index_o <= io_wdata_i[6:0];
      if (mix_wr && mixer_index_o == MIX_CFG) mix40_reg <= io_wdata_i[1:0];
      if (mix_disable) mix40_reg <= 2'h0;
      if (mix_wr && mixer_index_o == MIX_SER) begin
        mix48_reg <= {io_wdata_i[SER_SW_BIT], io_wdata_i[SER_RST_BIT], io_wdata_i[SER_WT_BIT]};
      end
    end
  end

  // ------------------------------------------------------------
  // Port +6: reset holds, activity and serial status
  // ------------------------------------------------------------
  logic fm_acc, act6_clr, act5_clr;
  logic fm_alias_hit, joy_hit;
  assign fm_alias_hit = mix40_reg[MIX_FMALIAS_BIT] && io_addr_i[9:2] == fm_base[9:2];
  assign fm_acc = (in_aud && (ofs <= OFS_FM3 || ofs == OFS_FM8 || ofs == OFS_FM9)) || fm_alias_hit;
  assign act6_clr = in_aud && (ofs == OFS_CMD || ofs == OFS_BUF);
  assign act5_clr = (io_dack_i && (io_rd_i || io_wr_i)) || (in_aud && ((io_wr_i
    && (ofs == OFS_F2 || ofs == OFS_FM3 || ofs == OFS_RST || ofs == OFS_CMD)) || (io_rd_i
    && (ofs == OFS_F2 || ofs == OFS_FM3 || ofs == OFS_RDD))));
  // A status read sets all three; it wins over a coincident clear
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      act_reg <= ACT_ALL;
      core_hold_reset_o <= 1'b0;
      fifo_hold_reset_o <= 1'b0;
    end else begin
      if (io_rd_i && in_aud && ofs == OFS_RST) begin
        act_reg <= ACT_ALL;
      end else begin
        if (midi_access_i || ((io_rd_i || io_wr_i) && fm_acc)) act_reg[2] <= 1'b0;
        if ((io_rd_i || io_wr_i) && act6_clr) act_reg[1] <= 1'b0;
        if (act5_clr) act_reg[0] <= 1'b0;
      end
      if (io_wr_i && in_aud && ofs == OFS_RST) begin
        core_hold_reset_o <= io_wdata_i[0];
        fifo_hold_reset_o <= io_wdata_i[1];
      end
      if (mix_disable) begin
        core_hold_reset_o <= 1'b0;
        fifo_hold_reset_o <= 1'b0;
      end
    end
  end

  // Wavetable bit clock counts as active while it kept toggling lately
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      wt_prev_reg <= 1'b0;
      wt_cnt_reg <= '0;
    end else begin
      wt_prev_reg <= wavetable_bit_clock_i;
      if (wavetable_bit_clock_i != wt_prev_reg) wt_cnt_reg <= $bits(wt_cnt_reg)'(WT_IDLE_CYCLES);
      else if (wt_cnt_reg != '0) wt_cnt_reg <= wt_cnt_reg - 1'b1;
    end
  end
  logic ser_act;
  assign ser_act = mix48_reg[2] | mix48_reg[1] | serial_takeover_pin_i
                   | (mix48_reg[0] && wt_cnt_reg != '0);

  // ------------------------------------------------------------
  // Read data and decode outputs
  // ------------------------------------------------------------
  assign joy_hit = mix40_reg[MIX_JOYFIX_BIT] ? (scw_reg[SCW_AUD_EN] && io_addr_i == JOY_FIXED)
                 : (scw_reg[SCW_JOY_EN] && io_addr_i == joy_base + 10'h001);
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      io_rdata_o <= 8'hFF;
      io_claim_o <= 1'b0;
      audio_hit_o <= 1'b0;
      fm_hit_o <= 1'b0;
      joy_hit_o <= 1'b0;
      system_control_word_o <= SCW_RESET;
    end else begin
      system_control_word_o <= scw_reg;
      audio_hit_o <= (io_rd_i || io_wr_i) && in_aud;
      fm_hit_o <= (io_rd_i || io_wr_i) && fm_acc;
      joy_hit_o <= (io_rd_i || io_wr_i) && joy_hit;
      io_claim_o <= 1'b0;
      io_rdata_o <= 8'hFF;
      if (io_rd_i && hi_mode && io_addr_i == SC_DATA_ADDR) begin
        io_claim_o <= 1'b1;
        io_rdata_o <= scw_reg;
      end else if (io_rd_i && in_aud && ofs == OFS_IDX) begin
        io_claim_o <= 1'b1;
        io_rdata_o <= {1'b0, mixer_index_o};
      end else if (io_rd_i && in_aud && ofs == OFS_DAT) begin
        io_claim_o <= 1'b1;
        io_rdata_o <= mixer_rdata_i;
      end else if (io_rd_i && in_aud && ofs == OFS_RST) begin
        io_claim_o <= 1'b1;
        io_rdata_o <= {act_reg, ser_act, digital_powered_i, midi_cmd_active_i,
                       fifo_hold_reset_o, core_hold_reset_o};
      end
    end
  end

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!arst_n_i);
  sequence seq_fm_step;
    !hi_mode && rd_n && key_reg == K9 && !mix_disable && !leg_done;
  endsequence
  sequence seq_sc_write;
    hi_mode && io_wr_i && unlock_reg && io_addr_i == SC_DATA_ADDR && scidx_reg == 8'h00;
  endsequence
  key_fm_set_a: assert property ((seq_fm_step and fm_c[2])
    |=> scw_reg[7:6] == $past(io_addr_i[5:4]) && key_reg == K0)
    else $error("fm base not taken from tenth read");
  key_write_abort_a: assert property (wr_n && !hi_mode |=> key_reg == K0)
    else $error("write did not abort key");
  key_audio_a: assert property (!hi_mode && rd_n && key_reg == K7 && !mix_disable
    |=> scw_reg[2] == $past(aud_c[2]) && key_reg == K8)
    else $error("audio enable wrong after eighth read");
  leg_enable_a: assert property (leg_done |=> scw_reg[2] && !armed_reg ##1 leg_reg == 4'h0)
    else $error("legacy key did not enable audio");
  mode_ignore_a: assert property (!hi_mode && io_wr_i && io_addr_i == SC_UNLOCK_ADDR
    |=> !$changed(unlock_reg))
    else $error("unlock honoured in key mode");
  sc_write_a: assert property ((seq_sc_write and !mix_disable)
    |=> scw_reg == $past(io_wdata_i) ##1 system_control_word_o == $past(io_wdata_i, 2))
    else $error("control word write lost");
  status_set_a: assert property (io_rd_i && in_aud && ofs == OFS_RST
    |=> act_reg == 3'h7 && io_claim_o)
    else $error("status read did not set activity");
  mix_disable_a: assert property (mix_disable |=> scw_reg == 8'h00 && armed_reg)
    else $error("mixer disable did not reset configuration");
  lock_data_a: assert property (hi_mode && io_wr_i && io_addr_i == SC_LOCK_ADDR
    |=> !unlock_reg)
    else $error("lock strobe ignored");
endmodule // isa_address_key_config

// [test/isa_address_key_config_test.sv]
// Testbench: key methods, control word, status and mixer ports
module isa_address_key_config_test;
  timeunit 1ns;
  timeprecision 100ps;

  // -----------------------------------------------------------
  // Signals and bench state
  // -----------------------------------------------------------
  logic clock_i = 1'b0;
  logic arst_n_i = 1'b0;
  logic [9:0] io_addr;
  logic io_rd, io_wr, io_dack, io_claim;
  logic [7:0] io_wdata, io_rdata, mix_rd = 8'h00, mix_wd, scw, q, d;
  logic mode_pin = 1'b0, ser_pin = 1'b0, pwr_pin = 1'b0, midi_pin = 1'b0;
  logic wt_clk = 1'b0, midi_acc = 1'b0;
  logic [6:0] mix_idx;
  logic mix_wr, core_h, fifo_h, a_hit, f_hit, j_hit, c;
  logic [1:0] a, j, f;
  logic [9:0] base;
  logic [2:0] act_exp[3] = '{3'b110, 3'b101, 3'b011};
  logic [9:0] nk[7] = '{10'h22B, 10'h229, 10'h22F, 10'h22D, 10'h22D, 10'h22F, 10'h229};
  logic [9:0] leg[10] = '{10'h229, 10'h229, 10'h229, 10'h22B, 10'h229,
                          10'h22B, 10'h229, 10'h229, 10'h22B, 10'h229};
  int n_errors = 0;
  int samples_checked = 0;
  int cyc = 0;

  always #10 clock_i = ~clock_i;

  isa_host_model u_host (.clock_i(clock_i), .io_addr_o(io_addr), .io_rd_o(io_rd),
    .io_wr_o(io_wr), .io_dack_o(io_dack), .io_wdata_o(io_wdata),
    .io_rdata_i(io_rdata), .io_claim_i(io_claim));

  // Short idle window keeps the wavetable check quick
  isa_address_key_config #(.WT_IDLE_CYCLES(8)) u_dut (.clock_i(clock_i),
    .arst_n_i(arst_n_i), .io_addr_i(io_addr), .io_rd_i(io_rd), .io_wr_i(io_wr),
    .io_dack_i(io_dack), .io_wdata_i(io_wdata), .io_rdata_o(io_rdata),
    .io_claim_o(io_claim), .addr_method_select_pin_i(mode_pin),
    .serial_takeover_pin_i(ser_pin), .wavetable_bit_clock_i(wt_clk),
    .midi_cmd_active_i(midi_pin), .digital_powered_i(pwr_pin), .midi_access_i(midi_acc),
    .mixer_rdata_i(mix_rd), .mixer_index_o(mix_idx), .mixer_wdata_o(mix_wd),
    .mixer_wr_o(mix_wr), .system_control_word_o(scw), .core_hold_reset_o(core_h),
    .fifo_hold_reset_o(fifo_h), .audio_hit_o(a_hit), .fm_hit_o(f_hit),
    .joy_hit_o(j_hit));

  // -----------------------------------------------------------
  // Shared tasks
  // -----------------------------------------------------------
  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // Reference model: control word from the three base addresses read
  function automatic logic [7:0] key_word(input int aud, input int joy, input int fm);
    key_word = 8'((fm - 'h388) / 'h10 * 64 + (joy - 'h200) * 16 + 12 + (aud - 'h220) / 'h10);
  endfunction

  task automatic rd(input logic [9:0] ad);
    u_host.access(1'b0, ad, 8'h00, q, c);
  endtask

  task automatic wr(input logic [9:0] ad, input logic [7:0] dt);
    u_host.access(1'b1, ad, dt, q, c);
  endtask

  // The visible copy lags the taking edge by one more cycle
  task automatic scw_chk(input logic [7:0] e);
    @(posedge clock_i);
    #1;
    chk("control word", scw, e);
  endtask

  task automatic do_reset(input logic m);
    arst_n_i = 1'b0;
    mode_pin = m;
    repeat (10) @(posedge clock_i);
    #1;
    arst_n_i = 1'b1;
  endtask

  // New key, optionally broken by a write in mid-sequence
  task automatic newkey(input logic brk, input logic [1:0] a2, j2, f2);
    rd(10'h300);
    for (int i = 0; i < 7; i++) begin
      if (brk && i == 3) wr(10'h300, 8'h5A);
      rd(nk[i]);
    end
    rd(10'h220 + {4'h0, a2, 4'h0});
    rd(10'h200 + {8'h00, j2});
    rd(10'h388 + {4'h0, f2, 4'h0});
  endtask

  // Legacy key with an optional write or stray read before step six
  task automatic leg_key(input logic w, input logic [9:0] ins, input logic [9:0] fin);
    for (int i = 0; i < 10; i++) begin
      if (i == 5 && w) wr(ins, 8'h00);
      else if (i == 5 && ins != 10'h000) rd(ins);
      rd(leg[i]);
    end
    rd(fin);
  endtask

  task automatic end_of_test;
    $display("Comparisons %0d, mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // Hang guard well above the few hundred cycles the tests need
  always @(posedge clock_i) begin
    cyc++;
    if (cyc == 4000) begin
      n_errors++;
      end_of_test();
    end
  end

  // -----------------------------------------------------------
  // Main sequence
  // -----------------------------------------------------------
  initial begin
    a = 2'($urandom(38));
    j = 2'($urandom);
    f = 2'($urandom);
    ser_pin = 1'($urandom);
    pwr_pin = 1'($urandom);
    midi_pin = 1'($urandom);
    mix_rd = 8'($urandom);
    do_reset(1'b0);
    scw_chk(8'h00);
    rd(10'h300);
    chk("unmapped claim", {7'h00, c}, 8'h00);
    chk("unmapped data", q, 8'hFF);
    wr(10'h0F9, 8'h00);
    wr(10'h0E0, 8'h00);
    wr(10'h0E1, 8'hFF);
    scw_chk(8'h00);
    newkey(1'b1, a, j, f);
    scw_chk(8'h00);
    newkey(1'b0, a, j, f);
    scw_chk(key_word('h220 + a * 'h10, 'h200 + j, 'h388 + f * 'h10));
    leg_key(1'b0, 10'h000, 10'h250);
    scw_chk(key_word('h220 + a * 'h10, 'h200 + j, 'h388 + f * 'h10));
    $display("Test new key done");
    base = 10'h220 + {4'h0, a, 4'h0};
    wr(base + 10'h6, 8'h03);
    chk("hold bits", {6'h00, fifo_h, core_h}, 8'h03);
    rd(base + 10'h6);
    chk("status claim", {6'h00, c, a_hit}, 8'h03);
    foreach (act_exp[i]) begin
      if (i == 0) wr(base + 10'h6, 8'h03);
      else rd(base + (i == 1 ? 10'hC : 10'h8));
      rd(base + 10'h6);
      chk("status", q, {act_exp[i], ser_pin, pwr_pin, midi_pin, 2'b11});
    end
    rd(base + 10'h6);
    chk("status reread", q, {3'b111, ser_pin, pwr_pin, midi_pin, 2'b11});
    $display("Test status port done");
    wr(base + 10'h4, 8'h48);
    chk("mixer index", {1'b0, mix_idx}, 8'h48);
    rd(base + 10'h5);
    chk("mixer read", q, mix_rd);
    // Wavetable activity via mixer 48h bit 4 and a clock edge, plus a MIDI access
    wr(base + 10'h5, 8'h10);
    ser_pin = 1'b0;
    wt_clk = 1'b1;
    midi_acc = 1'b1;
    @(posedge clock_i);
    #1;
    midi_acc = 1'b0;
    rd(base + 10'h6);
    chk("serial active", q, {3'b011, 1'b1, pwr_pin, midi_pin, 2'b11});
    repeat (12) @(posedge clock_i);
    rd(base + 10'h6);
    chk("serial idle", q, {3'b111, 1'b0, pwr_pin, midi_pin, 2'b11});
    wt_clk = 1'b0;
    wr(base + 10'h4, 8'h40);
    wr(base + 10'h5, 8'h04);
    chk("mixer write", {mix_wr, mix_wd[6:0]}, 8'h84);
    scw_chk(8'h00);
    rd(base + 10'h6);
    chk("disabled claim", {7'h00, c}, 8'h00);
    leg_key(1'b1, 10'h300, 10'h250);
    scw_chk(8'h00);
    leg_key(1'b0, 10'h22D, 10'h250);
    scw_chk(8'h00);
    leg_key(1'b0, 10'h000, 10'h250);
    scw_chk(8'h07);
    $display("Test legacy key done");
    do_reset(1'b1);
    newkey(1'b0, a, j, f);
    scw_chk(8'h00);
    d = 8'($urandom) | 8'h04;
    wr(10'h0F9, 8'($urandom));
    wr(10'h0E0, 8'h00);
    wr(10'h0E1, d);
    wr(10'h0FB, 8'($urandom));
    scw_chk(d);
    rd(10'h0E1);
    chk("word readback", q, d);
    wr(10'h0E1, ~d);
    scw_chk(d);
    rd(10'h201 + {8'h00, d[5:4]});
    chk("joystick hit", {7'h00, j_hit}, {7'h00, d[3]});
    base = 10'h220 + {4'h0, d[1:0], 4'h0};
    wr(base + 10'h4, 8'h40);
    wr(base + 10'h5, 8'h03);
    rd(10'h201);
    chk("fixed joystick", {7'h00, j_hit}, 8'h01);
    rd(10'h388 + {4'h0, d[7:6], 4'h0});
    chk("fm alias", {7'h00, f_hit}, 8'h01);
    $display("Test control word done");
    end_of_test();
  end
endmodule // isa_address_key_config_test

// [test/isa_host_model.sv]
// Partner model: ISA host issuing single non-DMA I/O read and write cycles
module isa_host_model (
  // Clock
  input wire logic clock_i,
  // I/O cycle toward the block
  output logic [9:0] io_addr_o,
  output logic io_rd_o,
  output logic io_wr_o,
  output logic io_dack_o,
  output logic [7:0] io_wdata_o,
  input wire logic [7:0] io_rdata_i,
  input wire logic io_claim_i
);
  timeunit 1ns;
  timeprecision 100ps;

  // -----------------------------------------------------------
  // Idle bus at time zero
  // -----------------------------------------------------------
  initial begin
    io_addr_o = 10'h3FF;
    io_rd_o = 1'b0;
    io_wr_o = 1'b0;
    io_dack_o = 1'b0; // Programmed I/O only, never a DMA cycle
    io_wdata_o = 8'hFF;
  end

  // One access: driven just after an edge, held over the taking edge,
  // then dropped; no interrupt traffic can slip between key reads
  task automatic access(input logic wr, input logic [9:0] a, input logic [7:0] d,
      output logic [7:0] q, output logic c);
    @(posedge clock_i);
    #1;
    io_addr_o = a;
    io_wdata_o = d;
    io_rd_o = ~wr;
    io_wr_o = wr;
    @(posedge clock_i);
    #1;
    io_rd_o = 1'b0;
    io_wr_o = 1'b0;
    io_addr_o = ~a; // Released lines must not keep the last value
    io_wdata_o = ~d;
    q = io_rdata_i;
    c = io_claim_i;
  endtask
endmodule // isa_host_model
